//--- inc/epz_pkg.sv
package epz_pkg;
   // Clock
   localparam int EPZ_CLK_HZ = 25_000_000;
   localparam int EPZ_CYC_PER_US = EPZ_CLK_HZ / 1_000_000;
   // Register offsets (byte addresses)
   localparam logic [7:0] EPZ_OFS_WIDTH = 8'h00;
   localparam logic [7:0] EPZ_OFS_MINTIME = 8'h04;
   localparam logic [7:0] EPZ_OFS_INTERVAL = 8'h08;
   localparam logic [7:0] EPZ_OFS_METHOD = 8'h0C;
   localparam logic [7:0] EPZ_OFS_SOURCE = 8'h10;
   localparam logic [7:0] EPZ_OFS_APPLY = 8'h14;
   localparam logic [7:0] EPZ_OFS_STATUS = 8'h18;
   // Field widths
   localparam int EPZ_WIDTH_W = 15;
   localparam int EPZ_MINTIME_W = 9;
   localparam int EPZ_INTERVAL_W = 29;
   localparam int EPZ_STRETCH_W = 20;
   // Settings after reset
   localparam logic [EPZ_WIDTH_W-1:0] EPZ_RST_WIDTH = 15'h0000;
   localparam logic [EPZ_MINTIME_W-1:0] EPZ_RST_MINTIME = 9'h000;
   localparam logic [EPZ_INTERVAL_W-1:0] EPZ_RST_INTERVAL = 29'h00000000;
   localparam logic EPZ_RST_METHOD = 1'b0;
   localparam logic [1:0] EPZ_RST_SOURCE = 2'h0;
   // Pulse source selection
   typedef enum logic [1:0] {
      EPZ_SRC_MOTOR,
      EPZ_SRC_PARALLEL,
      EPZ_SRC_SERIAL
   } epz_src_e;
endpackage

//--- inc/epz_step_if.sv
`timescale 1ns/100ps
// Step requests to the quadrature generator and its outputs
interface epz_step_if;
   logic step;
   logic dir;
   logic a;
   logic b;
   logic a_rise;
   logic edge_out;
   modport src (output step, output dir, input a, input b, input a_rise, input edge_out);
   modport gen (input step, input dir, output a, output b, output a_rise, output edge_out);
endinterface

//--- verilog/epz_quad_gen.sv
`timescale 1ns/100ps
module epz_quad_gen (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Step requests in, quadrature out
   epz_step_if.gen st
);
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic a;
   logic b;
   logic next_a;
   logic next_b;

   // Gray phase walk; up means B leads A
   always_comb begin
      next_phase = phase;
      if (st.step) begin
         next_phase = st.dir ? phase + 2'h1 : phase - 2'h1;
      end
      next_a = next_phase[1];
      next_b = next_phase[1] ^ next_phase[0];
   end

   // Phase and pin registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase <= 2'h0;
         a <= 1'b0;
         b <= 1'b0;
      end else begin
         phase <= next_phase;
         a <= next_a;
         b <= next_b;
      end
   end

   assign st.a = a;
   assign st.b = b;
   assign st.a_rise = st.step && !a && next_a;
   assign st.edge_out = st.step;
endmodule

//--- verilog/epz_pulse_out.sv
`timescale 1ns/100ps
module epz_pulse_out
   import epz_pkg::*;
#(
   parameter int CYC_PER_US = EPZ_CYC_PER_US
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Motor encoder pins
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic enc_z_i,
   // Parallel scale pins
   input wire logic scl_a_i,
   input wire logic scl_b_i,
   input wire logic scl_z_i,
   // Serial absolute scale position, quarter pulse units
   input wire logic [31:0] abs_pos_i,
   input wire logic abs_valid_i,
   // Pulse outputs to host
   output logic out_a_o,
   output logic out_b_o,
   output logic out_z_o
);
   epz_step_if st();

   epz_quad_gen u_gen (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .st(st)
   );

   // Settings: software copy and power-up copy
   logic [EPZ_WIDTH_W-1:0] sw_width, act_width, next_sw_width, next_act_width;
   logic [EPZ_MINTIME_W-1:0] sw_mintime, act_mintime, next_sw_mintime, next_act_mintime;
   logic [EPZ_INTERVAL_W-1:0] sw_interval, act_interval, next_sw_interval, next_act_interval;
   logic sw_method, act_method, next_sw_method, next_act_method;
   logic [1:0] sw_source, act_source, next_sw_source, next_act_source;
   logic [31:0] rdata, next_rdata;
   logic first_seen;

   // Register writes; apply models control power-up
   always_comb begin
      next_sw_width = sw_width;
      next_sw_mintime = sw_mintime;
      next_sw_interval = sw_interval;
      next_sw_method = sw_method;
      next_sw_source = sw_source;
      next_act_width = act_width;
      next_act_mintime = act_mintime;
      next_act_interval = act_interval;
      next_act_method = act_method;
      next_act_source = act_source;
      if (wr_i) begin
         case (addr_i)
            EPZ_OFS_WIDTH: next_sw_width = wdata_i[EPZ_WIDTH_W-1:0];
            EPZ_OFS_MINTIME: next_sw_mintime = wdata_i[EPZ_MINTIME_W-1:0];
            EPZ_OFS_INTERVAL: next_sw_interval = wdata_i[EPZ_INTERVAL_W-1:0];
            EPZ_OFS_METHOD: next_sw_method = wdata_i[0];
            EPZ_OFS_SOURCE: next_sw_source = wdata_i[1:0];
            EPZ_OFS_APPLY: begin
               if (wdata_i[0]) begin
                  next_act_width = sw_width;
                  next_act_mintime = sw_mintime;
                  next_act_interval = sw_interval;
                  next_act_method = sw_method;
                  next_act_source = sw_source;
               end
            end
            default: ;
         endcase
      end
      next_rdata = 32'h00000000;
      if (rd_i) begin
         case (addr_i)
            EPZ_OFS_WIDTH: next_rdata = {17'h00000, sw_width};
            EPZ_OFS_MINTIME: next_rdata = {23'h000000, sw_mintime};
            EPZ_OFS_INTERVAL: next_rdata = {3'h0, sw_interval};
            EPZ_OFS_METHOD: next_rdata = {31'h00000000, sw_method};
            EPZ_OFS_SOURCE: next_rdata = {30'h00000000, sw_source};
            EPZ_OFS_STATUS: begin
               next_rdata = {25'h0000000, act_source, act_method, first_seen,
                             out_z_o, out_b_o, out_a_o};
            end
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sw_width <= EPZ_RST_WIDTH;
         sw_mintime <= EPZ_RST_MINTIME;
         sw_interval <= EPZ_RST_INTERVAL;
         sw_method <= EPZ_RST_METHOD;
         sw_source <= EPZ_RST_SOURCE;
         act_width <= EPZ_RST_WIDTH;
         act_mintime <= EPZ_RST_MINTIME;
         act_interval <= EPZ_RST_INTERVAL;
         act_method <= EPZ_RST_METHOD;
         act_source <= EPZ_RST_SOURCE;
         rdata <= 32'h00000000;
      end else begin
         sw_width <= next_sw_width;
         sw_mintime <= next_sw_mintime;
         sw_interval <= next_sw_interval;
         sw_method <= next_sw_method;
         sw_source <= next_sw_source;
         act_width <= next_act_width;
         act_mintime <= next_act_mintime;
         act_interval <= next_act_interval;
         act_method <= next_act_method;
         act_source <= next_act_source;
         rdata <= next_rdata;
      end
   end
   assign rdata_o = rdata;

   // Two-stage synchronisers for the six pins
   logic [5:0] pin_s1, pin_s2;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
      end else begin
         pin_s1 <= {scl_z_i, scl_b_i, scl_a_i, enc_z_i, enc_b_i, enc_a_i};
         pin_s2 <= pin_s1;
      end
   end

   // Quadrature decode of the selected pin pair
   logic src_par, dec_a, dec_b, dec_z;
   logic [1:0] dec_idx, prev_idx, idx_diff;
   logic [31:0] out_pos, next_out_pos;
   logic [EPZ_INTERVAL_W-1:0] a_cnt, next_a_cnt;
   logic next_first_seen, z_evt, z_raw, z_hold;
   logic prev_raw, next_prev_raw;
   logic [EPZ_WIDTH_W-1:0] mot_cnt, next_mot_cnt;
   logic [EPZ_STRETCH_W-1:0] str_cnt, next_str_cnt, str_load;

   assign src_par = (act_source == EPZ_SRC_PARALLEL);
   assign dec_a = src_par ? pin_s2[3] : pin_s2[0];
   assign dec_b = src_par ? pin_s2[4] : pin_s2[1];
   assign dec_z = src_par ? pin_s2[5] : pin_s2[2];
   assign dec_idx = {dec_a, dec_a ^ dec_b};
   assign idx_diff = dec_idx - prev_idx;
   assign str_load = EPZ_STRETCH_W'(act_mintime * CYC_PER_US);

   // Step source: decoded pins or tracking of serial position
   always_comb begin
      st.step = 1'b0;
      st.dir = 1'b1;
      next_out_pos = out_pos;
      if (act_source == EPZ_SRC_SERIAL) begin
         if (out_pos != abs_pos_i && abs_valid_i) begin
            st.step = 1'b1;
            st.dir = $signed(abs_pos_i) > $signed(out_pos);
            next_out_pos = st.dir ? out_pos + 32'h00000001 : out_pos - 32'h00000001;
         end
      end else if (idx_diff == 2'h1 || idx_diff == 2'h3) begin
         st.step = 1'b1;
         st.dir = (idx_diff == 2'h1);
      end
   end

   // Index generation per source
   always_comb begin
      next_a_cnt = a_cnt;
      next_first_seen = first_seen;
      next_mot_cnt = mot_cnt;
      z_evt = 1'b0;
      z_raw = 1'b0;
      case (act_source)
         EPZ_SRC_SERIAL: begin
            if (act_interval == '0) begin
               z_raw = (out_pos == 32'h00000000) && abs_valid_i;
            end else if (st.step && next_out_pos == 32'h00000000 && !first_seen) begin
               z_evt = 1'b1;
               next_first_seen = 1'b1;
               next_a_cnt = '0;
            end else if (first_seen && st.a_rise) begin
               if (a_cnt + 29'h00000001 >= act_interval) begin
                  z_evt = 1'b1;
                  next_a_cnt = '0;
               end else begin
                  next_a_cnt = a_cnt + 29'h00000001;
               end
            end
         end
         EPZ_SRC_PARALLEL: z_raw = dec_z;
         default: begin
            z_raw = dec_z;
            if (dec_z && !prev_raw) begin
               next_mot_cnt = act_width;
            end else if (mot_cnt != '0 && st.edge_out) begin
               next_mot_cnt = mot_cnt - 15'h0001;
            end
         end
      endcase
      next_prev_raw = (act_source == EPZ_SRC_SERIAL) ? z_raw : dec_z;
      next_str_cnt = str_cnt;
      if (act_source == EPZ_SRC_SERIAL && (z_evt || (z_raw && !prev_raw))) begin
         next_str_cnt = str_load;
      end else if (str_cnt != '0) begin
         next_str_cnt = str_cnt - 20'h00001;
      end
      z_hold = (str_cnt != '0) || (mot_cnt != '0);
   end

   // Decode, tracking and index state
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_idx <= 2'h0;
         out_pos <= 32'h00000000;
         a_cnt <= '0;
         first_seen <= 1'b0;
         prev_raw <= 1'b0;
         mot_cnt <= '0;
         str_cnt <= '0;
      end else begin
         prev_idx <= dec_idx;
         out_pos <= next_out_pos;
         a_cnt <= next_a_cnt;
         first_seen <= next_first_seen;
         prev_raw <= next_prev_raw;
         mot_cnt <= next_mot_cnt;
         str_cnt <= next_str_cnt;
      end
   end

   // Output select: pass-through or regenerated
   logic pass;
   assign pass = src_par && !act_method;
   assign out_a_o = pass ? pin_s2[3] : st.a;
   assign out_b_o = pass ? pin_s2[4] : st.b;
   assign out_z_o = z_raw || z_evt || z_hold;
endmodule

//--- tb/epz_host_model.sv
`timescale 1ns/100ps
module epz_host_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Pulses from the block
   input wire logic a_i,
   input wire logic b_i,
   input wire logic z_i,
   // Counted position and index count
   output int pos_o,
   output int nz_o
);
   logic [1:0] g;
   logic [1:0] g_q;
   logic z_q;
   // Phase index, AB 00,01,11,10 counts up
   assign g = {a_i, a_i ^ b_i};
   // Quadrature counter and index edge counter
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         g_q <= 2'h0;
         z_q <= 1'b0;
         pos_o <= 0;
         nz_o <= 0;
      end else begin
         g_q <= g;
         z_q <= z_i;
         if (g - g_q == 2'h1) pos_o <= pos_o + 1;
         if (g - g_q == 2'h3) pos_o <= pos_o - 1;
         if (z_i && !z_q) nz_o <= nz_o + 1;
      end
   end
endmodule

//--- tb/epz_pulse_out_monitor.sv
`timescale 1ns/100ps
module epz_pulse_out_monitor
   import epz_pkg::*;
#(
   parameter int CYC_PER_US = EPZ_CYC_PER_US
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic scl_a_i,
   input wire logic scl_b_i,
   input wire logic scl_z_i,
   input wire logic out_a_o,
   input wire logic out_b_o,
   input wire logic out_z_o
);
   logic [1:0] sw_src, act_src;
   logic sw_meth, act_meth;
   logic [8:0] sw_min, act_min;
   int zlen;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Shadow of written and applied settings, index high time
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         {sw_src, act_src, sw_meth, act_meth, sw_min, act_min} <= '0;
         zlen <= 0;
      end else begin
         zlen <= out_z_o ? zlen + 1 : 0;
         if (wr_i && addr_i == EPZ_OFS_SOURCE) sw_src <= wdata_i[1:0];
         if (wr_i && addr_i == EPZ_OFS_METHOD) sw_meth <= wdata_i[0];
         if (wr_i && addr_i == EPZ_OFS_MINTIME) sw_min <= wdata_i[8:0];
         if (wr_i && addr_i == EPZ_OFS_APPLY && wdata_i[0]) begin
            {act_src, act_meth, act_min} <= {sw_src, sw_meth, sw_min};
         end
      end
   end
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_unmapped_rd: assert property (rd_i && addr_i == 8'h1C |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_width_bits: assert property (rd_i && addr_i == EPZ_OFS_WIDTH |=> rdata_o[31:15] == 0)
      else $error("width upper bits set");
   a_write_readback: assert property (wr_i && addr_i == EPZ_OFS_WIDTH ##1 !wr_i ##1
      rd_i && addr_i == EPZ_OFS_WIDTH |=> rdata_o[14:0] == $past(wdata_i[14:0], 3))
      else $error("width readback wrong");
   a_status_applied: assert property (rd_i && addr_i == EPZ_OFS_STATUS
      |=> rdata_o[6:4] == {$past(act_src), $past(act_meth)})
      else $error("status not the applied settings");
   a_quad_one_edge: assert property ($stable(act_src) && $stable(act_meth)
      |-> !($changed(out_a_o) && $changed(out_b_o)))
      else $error("A and B changed together");
   a_pass_ab: assert property (act_src == EPZ_SRC_PARALLEL && !act_meth
      |-> out_a_o == $past(scl_a_i, 2) && out_b_o == $past(scl_b_i, 2))
      else $error("A or B not passed through");
   a_pass_z: assert property (act_src == EPZ_SRC_PARALLEL |-> out_z_o == $past(scl_z_i, 2))
      else $error("index not passed through");
   a_z_stretch: assert property ($fell(out_z_o) && act_src == EPZ_SRC_SERIAL
      |-> zlen >= act_min * CYC_PER_US)
      else $error("scale index shorter than minimum");
endmodule
bind epz_pulse_out epz_pulse_out_monitor #(.CYC_PER_US(CYC_PER_US)) epz_pulse_out_monitor_i (
   .clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .scl_a_i, .scl_b_i,
   .scl_z_i, .out_a_o, .out_b_o, .out_z_o);

//--- tb/tb_epz_pulse_out.sv
`timescale 1ns/100ps
module tb_epz_pulse_out;
   import epz_pkg::*;
   localparam logic [31:0] MSK [5] = '{32'h7FFF, 32'h1FF, 32'h1FFFFFFF, 32'h1, 32'h3};
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic enc_a_i = 1'b0, enc_b_i = 1'b0, enc_z_i = 1'b0;
   logic scl_a_i = 1'b0, scl_b_i = 1'b0, scl_z_i = 1'b0;
   logic [31:0] abs_pos_i = 32'h0;
   logic abs_valid_i = 1'b0;
   logic out_a_o, out_b_o, out_z_o;
   int pos, nz, p0, z0, q = 0, n_mismatch = 0, n_checks = 0;
   logic [31:0] rv;
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   epz_pulse_out #(.CYC_PER_US(1)) epz_pulse_out_i (.clk_i, .reset_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .enc_a_i, .enc_b_i, .enc_z_i, .scl_a_i, .scl_b_i, .scl_z_i,
      .abs_pos_i, .abs_valid_i, .out_a_o, .out_b_o, .out_z_o);
   epz_host_model epz_host_model_i (.clk_i, .reset_i, .a_i(out_a_o), .b_i(out_b_o),
      .z_i(out_z_o), .pos_o(pos), .nz_o(nz));
   // Comparison, bus cycles and pin stimulus
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(rv, exp);
   endtask
   task cfg(input logic [1:0] s, input logic m, input logic [31:0] iv);
      wr(EPZ_OFS_WIDTH, 32'h0);
      wr(EPZ_OFS_MINTIME, 32'h5);
      wr(EPZ_OFS_INTERVAL, iv);
      wr(EPZ_OFS_METHOD, {31'h0, m});
      wr(EPZ_OFS_SOURCE, {30'h0, s});
      wr(EPZ_OFS_APPLY, 32'h1);
      rd(EPZ_OFS_STATUS);
      check({29'h0, rv[6:4]}, {29'h0, s, m});
   endtask
   task move(input int n);
      repeat (n < 0 ? -n : n) begin
         @(posedge clk_i);
         q = q + (n < 0 ? -1 : 1);
         {enc_a_i, scl_a_i} <= {2{q[1]}};
         {enc_b_i, scl_b_i} <= {2{q[1] ^ q[0]}};
         repeat (4) @(posedge clk_i);
      end
      @(negedge clk_i);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      // Reset values, field widths, unmapped place, apply-only effect
      for (int i = 0; i < 5; i++) begin
         rdc(8'(4 * i), 32'h0);
         wr(8'(4 * i), 32'hFFFFFFFF);
         rdc(8'(4 * i), MSK[i]);
      end
      rdc(8'h1C, 32'h0);
      rdc(EPZ_OFS_STATUS, 32'h0);
      $display("test registers done");
      // Motor, parallel direct and parallel regenerated
      for (int k = 0; k < 3; k++) begin
         cfg(k == 0 ? 2'h0 : 2'h1, k == 2, 32'h0);
         p0 = pos;
         z0 = nz;
         move(8);
         check(32'(pos - p0), 32'd8);
         move(-5);
         check(32'(pos - p0), 32'd3);
         @(posedge clk_i);
         {enc_z_i, scl_z_i} <= 2'h3;
         repeat (8) @(posedge clk_i);
         {enc_z_i, scl_z_i} <= 2'h0;
         repeat (8) @(posedge clk_i);
         check(32'(nz - z0), 32'd1);
         $display("test mode %0d done", k);
      end
      // Motor index held for the set number of output edges
      cfg(2'h0, 1'b0, 32'h0);
      wr(EPZ_OFS_WIDTH, 32'd2);
      wr(EPZ_OFS_APPLY, 32'h1);
      @(posedge clk_i);
      enc_z_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      enc_z_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check({31'h0, out_z_o}, 32'h1);
      move(1);
      check({31'h0, out_z_o}, 32'h1);
      move(1);
      check({31'h0, out_z_o}, 32'h0);
      $display("test motor width done");
      // Serial scale, index only at absolute zero
      cfg(EPZ_SRC_SERIAL, 1'b0, 32'h0);
      @(posedge clk_i);
      abs_valid_i <= 1'b1;
      abs_pos_i <= 32'd8;
      repeat (30) @(posedge clk_i);
      check({31'h0, out_z_o}, 32'h0);
      z0 = nz;
      abs_pos_i <= 32'd0;
      repeat (30) @(posedge clk_i);
      check(32'(nz - z0), 32'd1);
      $display("test serial zero done");
      // Serial scale, first index at zero then every two A pulses
      cfg(EPZ_SRC_SERIAL, 1'b0, 32'd2);
      @(posedge clk_i);
      abs_pos_i <= -32'sd8;
      repeat (30) @(posedge clk_i);
      p0 = pos;
      z0 = nz;
      for (int i = -7; i <= 32; i++) begin
         abs_pos_i <= 32'(i);
         repeat (4) @(posedge clk_i);
      end
      repeat (20) @(posedge clk_i);
      check(32'(pos - p0), 32'd40);
      check(32'(nz - z0), 32'd5);
      $display("test serial interval done");
      give_verdict();
   end
endmodule
